// >>> src/eph_consts.svh
/*
 Timing counts, register offsets, field positions, reset values and line
 symbols of the Ethernet PHY digital core.
 Assumes the core runs from one 100 MHz clock and includes this header.
*/
`ifndef EPH_CONSTS_SVH
`define EPH_CONSTS_SVH
// Operation
// - 100M: MAC nibbles become a serial line bit stream.
// - Transmit order: 4B/5B, then scrambler, then NRZI.
// - Receive clock recovered from NRZI edges; NRZI converted back to NRZ.
// - Receive: descramble, 4B/5B decode, nibbles to the MAC side.
// - Generate the 125, 25 and 20 MHz timing bases internally; the core makes only 25 and 20 MHz enables from SYS_CLK.
// - Reference source follows the interface mode strap.
// - 10M: receive clock keeps running between frames.
// - 10M: short collision pulse after each transmitted frame.
// - 10M: transmit enable high over 20 ms disables transmitter, collision high.
// - After jabber, enable low over 250 ms re-enables, collision low.
// - Auto-negotiation on when strap or control bit 12 asks.
// - Pick highest common: 100FD, 100HD, 10FD, 10HD.
// - Partner without negotiation: mode from detected fixed signalling.
// - Management slave answers strapped address 1 to 7.
// - Address 0 is broadcast: reads and writes served.
// - 16-bit management registers; 0 to 6 standard, more vendor; the core decodes 0 to 4, and 5 and 6 come from the vendor store.
// - Frame: 32 ones preamble, start 01, opcode 10 read, 01 write.
// - PHY address, register address, turnaround Z0 or 10, 16 data bits.
// - Two lines: controller clock and shared data.
// - Upper two PHY address bits always zero.
`define EPH_CLK_MHZ 100
`define EPH_LINE_MHZ 25
`define EPH_TICK_MHZ 20
`define EPH_JAB_MS 20
`define EPH_UNJAB_MS 250
`define EPH_SQE_NS 1000
`define EPH_PRE_ONES 6'h20
`define EPH_LOCK_BITS 5'h1E
`define EPH_4B5B 80'hEF37_ABDA_727B_96AA_D13E
`define EPH_SYM_I 5'h1F
`define EPH_SYM_J 5'h18
`define EPH_SYM_K 5'h11
`define EPH_SYM_T 5'h0D
`define EPH_SYM_R 5'h07
`define EPH_OP_RD 2'h2
`define EPH_OP_WR 2'h1
`define EPH_REG_CTRL 5'h00
`define EPH_REG_STAT 5'h01
`define EPH_REG_ID1 5'h02
`define EPH_REG_ID2 5'h03
`define EPH_REG_ADV 5'h04
`define EPH_CTRL_SPEED 13
`define EPH_CTRL_AN 12
`define EPH_CTRL_ANRST 9
`define EPH_CTRL_DUP 8
`define EPH_ADV_LO 5
`define EPH_ADV_SEL 5'h01
`define EPH_LFSR_SEED 11'h7FF
`endif

// >>> src/eph_pkg.sv
/*
 Types shared by the Ethernet PHY digital core and its testbench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eph_pkg;
    typedef enum logic [2:0] {EM_NONE, EM_10H, EM_10F, EM_100H, EM_100F}
        eph_mode_e;
    typedef enum logic [1:0] {TP_IDLE, TP_K, TP_DATA, TP_R} eph_txph_e;
    typedef enum logic [2:0] {MS_PRE, MS_HDR, MS_TA, MS_RD, MS_WR}
        eph_mdio_e;
    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] d;
    } eph_rx_s;
    typedef struct packed {
        logic st;
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] ra;
    } eph_hdr_s;
endpackage

// >>> src/eph_regmem.sv
/*
 Vendor management register store, 32 words of 16 bits.
 Assumes one writer and one reader on the core clock; read data is
 registered and words never written read as zero.
*/
`timescale 1ns/1ps
module eph_regmem (
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    input wire logic [4:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [0:31];
    logic [31:0] vld_ff;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            vld_ff <= 32'h0000_0000;
        end else if (wr_en) begin
            vld_ff[wr_addr] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= vld_ff[rd_addr] ? mem[rd_addr] : 16'h0000;
        end
    end
endmodule

// >>> src/eph_core.sv
/*
 Digital core of a 10/100 PHY: 100M coding paths, timing bases, 10M
 collision test and jabber, auto-negotiation resolve, management slave.
 Assumes every input except SRST comes from outside the clock domain.
*/
`timescale 1ns/1ps
`include "eph_consts.svh"
module eph_core #(
    parameter int JAB_TICKS = `EPH_JAB_MS * `EPH_TICK_MHZ * 1000,
    parameter int UNJAB_TICKS = `EPH_UNJAB_MS * `EPH_TICK_MHZ * 1000,
    parameter logic [15:0] ID_HI = 16'h0A5A, // Arbitrary value.
    parameter logic [15:0] ID_LO = 16'h5A50 // Arbitrary value.
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [2:0] PHY_ADDRESS_STRAPS,
    input wire logic STRAP_AN_EN,
    input wire logic STRAP_SPEED,
    input wire logic STRAP_HALF,
    input wire logic [1:0] STRAP_REF_MODE,
    input wire logic TX_EN,
    input wire logic [3:0] TXD,
    output logic TX_NIB_STB,
    output logic TX_LINE,
    input wire logic RX_LINE,
    output logic RX_CLK,
    output logic RX_DV,
    output logic RX_ER,
    output logic [3:0] RXD,
    output logic CRS,
    output logic COL,
    input wire logic LP_AN_VALID,
    input wire logic [3:0] LP_ABILITY,
    input wire logic DET_100,
    input wire logic DET_10,
    output eph_pkg::eph_mode_e LINK_MODE,
    output logic AN_DONE,
    output logic [1:0] REF_SEL,
    input wire logic MDC,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE
);
    localparam int LINE_DIV = `EPH_CLK_MHZ / `EPH_LINE_MHZ;
    localparam int TICK_DIV = `EPH_CLK_MHZ / `EPH_TICK_MHZ;
    localparam int SQE_TICKS = `EPH_SQE_NS * `EPH_TICK_MHZ / 1000;

    function automatic logic [4:0] enc(input logic [3:0] n);
        logic [79:0] tab;
        tab = `EPH_4B5B;
        return tab[5 * n +: 5];
    endfunction

    function automatic logic [4:0] dec(input logic [4:0] s);
        logic [79:0] tab;
        logic [4:0] r;
        tab = `EPH_4B5B;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (tab[5 * i +: 5] == s) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic eph_pkg::eph_mode_e best(input logic [3:0] c);
        if (c[3]) return eph_pkg::EM_100F;
        else if (c[2]) return eph_pkg::EM_100H;
        else if (c[1]) return eph_pkg::EM_10F;
        else if (c[0]) return eph_pkg::EM_10H;
        else return eph_pkg::EM_NONE;
    endfunction

    // Pin synchronisers; only the second stage is read.
    logic [22:0] sy1_ff, sy2_ff;
    always_ff @(posedge SYS_CLK) begin
        sy1_ff <= {TX_EN, TXD, RX_LINE, LP_AN_VALID, LP_ABILITY, DET_100,
                   DET_10, MDC, MDIO_I, PHY_ADDRESS_STRAPS, STRAP_AN_EN,
                   STRAP_SPEED, STRAP_HALF, STRAP_REF_MODE};
        sy2_ff <= sy1_ff;
    end
    wire tx_en_s = sy2_ff[22];
    wire [3:0] txd_s = sy2_ff[21:18];
    wire rx_l = sy2_ff[17];
    wire lp_ok = sy2_ff[16];
    wire [3:0] lp_ab = sy2_ff[15:12];
    wire det100 = sy2_ff[11];
    wire det10 = sy2_ff[10];
    wire mdc_s = sy2_ff[9];
    wire mdio_s = sy2_ff[8];

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    // Timing bases: SYS_CLK stands in for the fastest rate.
    logic [1:0] d25_ff;
    logic [2:0] d20_ff;
    always_ff @(posedge SYS_CLK) begin
        if (SRST || d25_ff == 2'(LINE_DIV - 1)) d25_ff <= 2'h0;
        else d25_ff <= d25_ff + 2'h1;
        if (SRST || d20_ff == 3'(TICK_DIV - 1)) d20_ff <= 3'h0;
        else d20_ff <= d20_ff + 3'h1;
    end
    wire bit_en = d25_ff == 2'(LINE_DIV - 1);
    wire en20 = d20_ff == 3'(TICK_DIV - 1);
    a_bit_period: assert property (bit_en |=> !bit_en [*3] ##1 bit_en)
        else $error("line bit enable period wrong");
    a_tick_period: assert property (en20 |=> !en20 [*4] ##1 en20)
        else $error("timing tick period wrong");

    // Straps are caught while reset is held.
    logic [4:0] my_addr_ff;
    logic an_strap_ff;
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            my_addr_ff <= {2'h0, sy2_ff[7:5]};
            an_strap_ff <= sy2_ff[4];
            REF_SEL <= sy2_ff[1:0];
        end
    end

    // Control and advertisement registers.
    logic [15:0] ctrl_ff;
    logic [3:0] adv_ff;
    logic wr_go_ff, rd_go_ff;
    logic [15:0] wdat_ff;
    eph_pkg::eph_hdr_s hdr_ff;
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl_ff <= 16'h0000;
            ctrl_ff[`EPH_CTRL_SPEED] <= sy2_ff[3];
            ctrl_ff[`EPH_CTRL_AN] <= sy2_ff[4];
            ctrl_ff[`EPH_CTRL_DUP] <= ~sy2_ff[2];
            adv_ff <= sy2_ff[3] ? 4'hF : 4'h3;
        end else if (wr_go_ff && hdr_ff.ra == `EPH_REG_CTRL) begin
            ctrl_ff <= wdat_ff;
        end else if (wr_go_ff && hdr_ff.ra == `EPH_REG_ADV) begin
            adv_ff <= wdat_ff[`EPH_ADV_LO +: 4];
        end else begin
            ctrl_ff[`EPH_CTRL_ANRST] <= 1'b0;
        end
    end

    // Auto-negotiation resolve and parallel detection.
    wire an_en = an_strap_ff | ctrl_ff[`EPH_CTRL_AN];
    wire an_rst = ctrl_ff[`EPH_CTRL_ANRST];
    wire [3:0] common = adv_ff & lp_ab;
    eph_pkg::eph_mode_e mode_ff;
    logic done_ff;
    always_ff @(posedge SYS_CLK) begin
        if (SRST || an_rst) begin
            mode_ff <= eph_pkg::EM_NONE;
            done_ff <= 1'b0;
        end else if (!an_en) begin
            mode_ff <= best(4'h1 << {ctrl_ff[`EPH_CTRL_SPEED],
                                     ctrl_ff[`EPH_CTRL_DUP]});
            done_ff <= 1'b0;
        end else if (lp_ok) begin
            mode_ff <= best(common);
            done_ff <= 1'b1;
        end else begin
            done_ff <= det100 | det10;
            mode_ff <= det100 ? eph_pkg::EM_100H :
                       det10 ? eph_pkg::EM_10H : eph_pkg::EM_NONE;
        end
    end
    assign LINK_MODE = mode_ff;
    assign AN_DONE = done_ff;
    wire speed10 = mode_ff == eph_pkg::EM_10H || mode_ff == eph_pkg::EM_10F;
    wire half = mode_ff == eph_pkg::EM_10H || mode_ff == eph_pkg::EM_100H;
    a_an_top: assert property (an_en && lp_ok && !an_rst && common[3]
        |=> LINK_MODE == eph_pkg::EM_100F)
        else $error("common 100 full not chosen");
    a_an_second: assert property (an_en && lp_ok && !an_rst
        && common[3:2] == 2'h1 |=> LINK_MODE == eph_pkg::EM_100H)
        else $error("common 100 half not chosen");
    a_par_det: assert property (an_en && !lp_ok && !an_rst && det100
        |=> LINK_MODE == eph_pkg::EM_100H && AN_DONE)
        else $error("parallel detection missed 100");

    // Jabber supervision and collision test, counted on the 20 MHz tick.
    logic jab_ff, txen_d_ff;
    logic [22:0] jcnt_ff;
    logic [4:0] sqe_ff;
    always_ff @(posedge SYS_CLK) begin
        if (SRST || !speed10) begin
            jab_ff <= 1'b0;
            jcnt_ff <= 23'h00_0000;
        end else if (en20) begin
            if (tx_en_s != jab_ff) begin
                jcnt_ff <= jcnt_ff + 23'h00_0001;
            end else begin
                jcnt_ff <= 23'h00_0000;
            end
            if (!jab_ff && tx_en_s && jcnt_ff >= 23'(JAB_TICKS - 1)) begin
                jab_ff <= 1'b1;
                jcnt_ff <= 23'h00_0000;
            end
            if (jab_ff && !tx_en_s && jcnt_ff >= 23'(UNJAB_TICKS - 1)) begin
                jab_ff <= 1'b0;
                jcnt_ff <= 23'h00_0000;
            end
        end
    end
    always_ff @(posedge SYS_CLK) begin
        txen_d_ff <= SRST ? 1'b0 : tx_en_s;
        if (SRST) begin
            sqe_ff <= 5'h00;
        end else if (speed10 && txen_d_ff && !tx_en_s && !jab_ff) begin
            sqe_ff <= 5'(SQE_TICKS);
        end else if (en20 && sqe_ff != 5'h00) begin
            sqe_ff <= sqe_ff - 5'h01;
        end
    end
    a_jab_col: assert property (jab_ff |=> COL)
        else $error("collision low during jabber");
    a_jab_cause: assert property ($rose(jab_ff)
        |-> $past(tx_en_s) && $past(speed10))
        else $error("jabber without long enable");
    a_unjab: assert property ($fell(jab_ff) && speed10
        |-> !$past(tx_en_s))
        else $error("jabber released while enable high");
    a_sqe_pulse: assert property ($fell(tx_en_s) && speed10 && !jab_ff
        |=> ##1 COL)
        else $error("no collision test pulse");

    // 100M transmit: symbol select, scrambler, NRZI.
    eph_pkg::eph_txph_e tph_ff;
    logic [4:0] tsh_ff;
    logic [2:0] tbc_ff;
    logic [10:0] tlfsr_ff;
    wire tx_go = tx_en_s && !jab_ff;
    wire tkey = tlfsr_ff[10] ^ tlfsr_ff[8];
    wire scr_bit = tsh_ff[4] ^ tkey;
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            tph_ff <= eph_pkg::TP_IDLE;
            tsh_ff <= `EPH_SYM_I;
            tbc_ff <= 3'h0;
            tlfsr_ff <= `EPH_LFSR_SEED;
            TX_LINE <= 1'b0;
            TX_NIB_STB <= 1'b0;
        end else begin
            TX_NIB_STB <= 1'b0;
            if (bit_en) begin
                tlfsr_ff <= {tlfsr_ff[9:0], tkey};
                TX_LINE <= TX_LINE ^ scr_bit;
                tbc_ff <= tbc_ff + 3'h1;
                tsh_ff <= {tsh_ff[3:0], 1'b0};
                if (tbc_ff == 3'h4) begin
                    tbc_ff <= 3'h0;
                    TX_NIB_STB <= 1'b1;
                    case (tph_ff)
                        eph_pkg::TP_IDLE: begin
                            tsh_ff <= tx_go ? `EPH_SYM_J : `EPH_SYM_I;
                            if (tx_go) tph_ff <= eph_pkg::TP_K;
                        end
                        eph_pkg::TP_K: begin
                            tsh_ff <= `EPH_SYM_K;
                            tph_ff <= eph_pkg::TP_DATA;
                        end
                        eph_pkg::TP_DATA: begin
                            tsh_ff <= tx_go ? enc(txd_s) : `EPH_SYM_T;
                            if (!tx_go) tph_ff <= eph_pkg::TP_R;
                        end
                        eph_pkg::TP_R: begin
                            tsh_ff <= `EPH_SYM_R;
                            tph_ff <= eph_pkg::TP_IDLE;
                        end
                        default: begin
                            tsh_ff <= `EPH_SYM_I;
                            tph_ff <= eph_pkg::TP_IDLE;
                        end
                    endcase
                end
            end
        end
    end
    a_nrzi: assert property (bit_en && scr_bit |=> $changed(TX_LINE))
        else $error("NRZI did not toggle on a one");

    // 100M receive: edge-aligned bit clock, NRZI to NRZ, descrambler.
    logic rs3_ff, smp_ff, rlock_ff, rin_ff;
    logic [1:0] rph_ff;
    logic [4:0] lcnt_ff;
    logic [10:0] rlfsr_ff;
    logic [9:0] win_ff;
    logic [2:0] rbc_ff;
    eph_pkg::eph_rx_s rx_ff;
    wire rx_bit_en = rph_ff == 2'h2 && rx_l == rs3_ff;
    wire nrz = rx_l ^ smp_ff;
    wire rkey = rlfsr_ff[10] ^ rlfsr_ff[8];
    wire dbit = nrz ^ rkey;
    wire [9:0] nwin = {win_ff[8:0], dbit};
    wire [4:0] dsym = dec(nwin[4:0]);
    always_ff @(posedge SYS_CLK) begin
        rs3_ff <= rx_l;
        rph_ff <= (SRST || rx_l != rs3_ff) ? 2'h0 : rph_ff + 2'h1;
        if (SRST) begin
            smp_ff <= 1'b0;
            rlock_ff <= 1'b0;
            lcnt_ff <= 5'h00;
            rlfsr_ff <= `EPH_LFSR_SEED;
        end else if (rx_bit_en) begin
            smp_ff <= rx_l;
            // Idle is all ones, so the line gives the scrambler state.
            rlfsr_ff <= {rlfsr_ff[9:0], rlock_ff ? rkey : ~nrz};
            if (!rlock_ff) lcnt_ff <= lcnt_ff + 5'h01;
            if (lcnt_ff == `EPH_LOCK_BITS) rlock_ff <= 1'b1;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            win_ff <= 10'h3FF;
            rin_ff <= 1'b0;
            rbc_ff <= 3'h0;
            rx_ff <= '0;
        end else if (rx_bit_en && rlock_ff) begin
            win_ff <= nwin;
            rbc_ff <= (rbc_ff == 3'h4) ? 3'h0 : rbc_ff + 3'h1;
            if (!rin_ff && nwin == {`EPH_SYM_J, `EPH_SYM_K}) begin
                rin_ff <= 1'b1;
                rbc_ff <= 3'h0;
                rx_ff <= '{dv: 1'b1, er: 1'b0, d: 4'h5};
            end else if (rin_ff && rbc_ff == 3'h4) begin
                if (nwin[4:0] == `EPH_SYM_T || nwin[4:0] == `EPH_SYM_I) begin
                    rin_ff <= 1'b0;
                    rx_ff <= '0;
                end else begin
                    rx_ff <= '{dv: 1'b1, er: !dsym[4], d: dsym[3:0]};
                end
            end
        end
    end
    assign RX_DV = rx_ff.dv;
    assign RX_ER = rx_ff.er;
    assign RXD = rx_ff.d;
    assign CRS = rin_ff;

    // Receive clock from the recovered phase once locked, or free running in 10M and before lock.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            RX_CLK <= 1'b0;
            COL <= 1'b0;
        end else begin
            if (!speed10 && rlock_ff) RX_CLK <= rph_ff < 2'h2;
            else if (bit_en) RX_CLK <= ~RX_CLK;
            COL <= jab_ff || sqe_ff != 5'h00 ||
                   (half && tph_ff != eph_pkg::TP_IDLE && rin_ff);
        end
    end
    a_rxclk_run: assert property (speed10 |-> ##[1:8] $changed(RX_CLK))
        else $error("receive clock stopped");

    // Management slave; MDC edges found by sampling.
    eph_pkg::eph_mdio_e ms_ff;
    logic mdc_d_ff;
    logic [5:0] pcnt_ff;
    logic [3:0] bcnt_ff;
    logic [15:0] dsh_ff, rdat, mem_q;
    wire mdc_rise = mdc_s && !mdc_d_ff;
    eph_pkg::eph_hdr_s nh;
    assign nh = eph_pkg::eph_hdr_s'({hdr_ff[11:0], mdio_s});
    wire hit = nh.phy == 5'h00 || nh.phy == my_addr_ff;
    always_comb begin
        case (hdr_ff.ra)
            `EPH_REG_CTRL: rdat = ctrl_ff;
            `EPH_REG_STAT: rdat = {1'b0, 4'hF, 5'h00, done_ff, 2'h1,
                                   mode_ff != eph_pkg::EM_NONE, 2'h1};
            `EPH_REG_ID1: rdat = ID_HI;
            `EPH_REG_ID2: rdat = ID_LO;
            `EPH_REG_ADV: rdat = {7'h00, adv_ff, `EPH_ADV_SEL};
            default: rdat = mem_q;
        endcase
    end
    always_ff @(posedge SYS_CLK) begin
        mdc_d_ff <= SRST ? 1'b0 : mdc_s;
        wr_go_ff <= 1'b0;
        rd_go_ff <= 1'b0;
        if (SRST) begin
            ms_ff <= eph_pkg::MS_PRE;
            pcnt_ff <= 6'h00;
            bcnt_ff <= 4'h0;
            hdr_ff <= '0;
            dsh_ff <= 16'h0000;
            wdat_ff <= 16'h0000;
            MDIO_O <= 1'b0;
            MDIO_OE <= 1'b0;
        end else if (mdc_rise) begin
            bcnt_ff <= bcnt_ff + 4'h1;
            case (ms_ff)
                eph_pkg::MS_PRE: begin
                    bcnt_ff <= 4'h0;
                    hdr_ff <= '0;
                    if (mdio_s && pcnt_ff != `EPH_PRE_ONES) begin
                        pcnt_ff <= pcnt_ff + 6'h01;
                    end else if (!mdio_s) begin
                        pcnt_ff <= 6'h00;
                        if (pcnt_ff == `EPH_PRE_ONES) ms_ff <= eph_pkg::MS_HDR;
                    end
                end
                eph_pkg::MS_HDR: begin
                    hdr_ff <= nh;
                    if (bcnt_ff == 4'hC) begin
                        bcnt_ff <= 4'h0;
                        ms_ff <= eph_pkg::MS_PRE;
                        if (nh.st && hit && (nh.op == `EPH_OP_RD ||
                                             nh.op == `EPH_OP_WR)) begin
                            ms_ff <= eph_pkg::MS_TA;
                            rd_go_ff <= nh.op == `EPH_OP_RD;
                        end
                    end
                end
                eph_pkg::MS_TA: begin
                    if (hdr_ff.op == `EPH_OP_RD) begin
                        MDIO_OE <= 1'b1;
                        MDIO_O <= bcnt_ff[0] ? rdat[15] : 1'b0;
                        dsh_ff <= rdat;
                    end
                    if (bcnt_ff[0]) begin
                        bcnt_ff <= 4'h0;
                        ms_ff <= hdr_ff.op == `EPH_OP_RD ? eph_pkg::MS_RD
                                                         : eph_pkg::MS_WR;
                    end
                end
                eph_pkg::MS_RD: begin
                    dsh_ff <= {dsh_ff[14:0], 1'b0};
                    MDIO_O <= dsh_ff[14];
                    if (bcnt_ff == 4'hF) begin
                        MDIO_OE <= 1'b0;
                        MDIO_O <= 1'b0;
                        ms_ff <= eph_pkg::MS_PRE;
                    end
                end
                eph_pkg::MS_WR: begin
                    dsh_ff <= {dsh_ff[14:0], mdio_s};
                    if (bcnt_ff == 4'hF) begin
                        wdat_ff <= {dsh_ff[14:0], mdio_s};
                        wr_go_ff <= 1'b1;
                        ms_ff <= eph_pkg::MS_PRE;
                    end
                end
                default: begin
                    MDIO_OE <= 1'b0;
                    ms_ff <= eph_pkg::MS_PRE;
                end
            endcase
        end
    end
    a_mdio_addr: assert property (MDIO_OE |-> hdr_ff.op == `EPH_OP_RD
        && (hdr_ff.phy == 5'h00 || hdr_ff.phy == my_addr_ff))
        else $error("data line driven for a foreign frame");
    a_mdio_ta: assert property ($rose(MDIO_OE) |-> !MDIO_O
        && $past(ms_ff) == eph_pkg::MS_TA)
        else $error("turnaround bit not zero");

    c_jabber: cover property ($rose(jab_ff));
    c_read: cover property ($fell(MDIO_OE));
    c_write: cover property (wr_go_ff && hdr_ff.phy == 5'h00);
    c_rx_frame: cover property ($fell(rin_ff));

    eph_regmem u_mem (
        .clk(SYS_CLK),
        .srst(SRST),
        .wr_en(wr_go_ff),
        .wr_addr(hdr_ff.ra),
        .wr_data(wdat_ff),
        .rd_en(rd_go_ff),
        .rd_addr(hdr_ff.ra),
        .rd_data(mem_q)
    );
endmodule

// >>> sim/eph_station.sv
/*
 Management station model: makes MDC and drives MDIO frames.
 Assumes the bench gives MDIO the PHY output while MDIO_OE is high and drv otherwise.
*/
`timescale 1ns/1ps
module eph_station (
    input wire logic clk,
    input wire logic mdio,
    output logic mdc,
    output logic drv
);
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
    end
    // Data changes with MDC falling and is sampled just before it rises.
    task automatic bitx(input logic b, output logic s);
        @(posedge clk);
        mdc <= 1'b0;
        drv <= b;
        repeat (4) @(posedge clk);
        s = mdio;
        mdc <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
            input logic [4:0] ra, input logic [15:0] wd,
            output logic [15:0] rd);
        logic [63:0] w;
        logic s;
        w = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, wd};
        if (op == 2'h2) begin
            w[17:0] = 18'h3_FFFF;
        end
        for (int i = 63; i >= 0; i--) begin
            bitx(w[i], s);
            if (i < 16) begin
                rd[i] = s;
            end
        end
        @(posedge clk);
        mdc <= 1'b0;
        drv <= 1'b1;
    endtask
endmodule

// >>> sim/eph_core_tb.sv
/*
 Self-checking bench of the PHY core: management, auto-negotiation,
 receive clock, jabber and collision test.
 Assumes the station model drives MDC and MDIO, and that the transmit
 line may be looped straight back into the receiver.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
    end end
module eph_core_tb;
    logic clk = 0, srst = 1, lpv = 0, d100 = 0, d10 = 0, txen = 0;
    logic [3:0] lpa = 0, txd = 0, rxd;
    logic mdc, mdo, moe, drv, col, rxc, stb, txl, rdv, rer, crs, done;
    logic [1:0] refs;
    eph_pkg::eph_mode_e mode;
    int err_count = 0, cmp_count = 0, oe_n = 0;
    wire mdio = moe ? mdo : drv;
    always #5 clk = ~clk;
    always @(posedge clk) if (moe === 1'b1) oe_n <= oe_n + 1;
    eph_station st (.clk(clk), .mdio(mdio), .mdc(mdc), .drv(drv));
    eph_core #(.JAB_TICKS(40), .UNJAB_TICKS(100)) dut_u (
        .SYS_CLK(clk), .SRST(srst), .PHY_ADDRESS_STRAPS(3'h5),
        .STRAP_AN_EN(1'b1), .STRAP_SPEED(1'b1), .STRAP_HALF(1'b0),
        .STRAP_REF_MODE(2'h1), .TX_EN(txen), .TXD(txd), .TX_NIB_STB(stb),
        .TX_LINE(txl), .RX_LINE(txl), .RX_CLK(rxc), .RX_DV(rdv),
        .RX_ER(rer), .RXD(rxd), .CRS(crs), .COL(col), .LP_AN_VALID(lpv),
        .LP_ABILITY(lpa), .DET_100(d100), .DET_10(d10), .LINK_MODE(mode),
        .AN_DONE(done), .REF_SEL(refs), .MDC(mdc), .MDIO_I(mdio),
        .MDIO_O(mdo), .MDIO_OE(moe));
    // The line is looped back from reset on, so the descrambler locks on
    // the idle stream long before the first frame is sent.
    task automatic end_of_test;
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_mdio;
        logic [15:0] r;
        int n0;
        st.frame(2'h1, 5'h00, 5'h10, 16'hA5C3, r);
        st.frame(2'h2, 5'h05, 5'h10, 16'h0000, r);
        `CHK("rd strap", 16'hA5C3, r)
        st.frame(2'h1, 5'h05, 5'h11, 16'h3C5A, r);
        st.frame(2'h2, 5'h00, 5'h11, 16'h0000, r);
        `CHK("rd bcast", 16'h3C5A, r)
        n0 = oe_n;
        st.frame(2'h2, 5'h0D, 5'h10, 16'h0000, r);
        st.frame(2'h2, 5'h03, 5'h10, 16'h0000, r);
        `CHK("foreign oe", 0, oe_n - n0)
    endtask
    task automatic t_mode(input eph_pkg::eph_mode_e m);
        for (int k = 0; k < 200 && mode !== m; k++) @(posedge clk);
        `CHK("link mode", m, mode)
    endtask
    task automatic t_an;
        logic [3:0] t [4] = '{4'h8, 4'h6, 4'h3, 4'h1};
        eph_pkg::eph_mode_e m [4] = '{eph_pkg::EM_100F, eph_pkg::EM_100H,
            eph_pkg::EM_10F, eph_pkg::EM_10H};
        for (int i = 0; i < 4; i++) begin
            lpa <= t[i];
            lpv <= 1'b1;
            t_mode(m[i]);
            lpv <= 1'b0;
            repeat (10) @(posedge clk);
        end
        d100 <= 1'b1;
        t_mode(eph_pkg::EM_100H);
        d100 <= 1'b0;
        d10 <= 1'b1;
        t_mode(eph_pkg::EM_10H);
        `CHK("an done", 1'b1, done)
    endtask
    task automatic t_tx;
        int n = 0;
        // Full duplex, so looped-back frames raise no overlap collision.
        d10 <= 1'b0;
        lpa <= 4'h2;
        lpv <= 1'b1;
        t_mode(eph_pkg::EM_10F);
        for (int k = 0; k < 80; k++) @(posedge clk) n += rxc;
        `CHK("rx clk runs", 1'b1, n > 8 && n < 72)
        txen <= 1'b1;
        repeat (100) @(posedge clk);
        txen <= 1'b0;
        for (int k = 0; k < 300 && col !== 1'b1; k++) @(posedge clk);
        `CHK("test pulse", 1'b1, col)
        repeat (300) @(posedge clk);
        `CHK("pulse end", 1'b0, col)
        txen <= 1'b1;
        repeat (600) @(posedge clk);
        `CHK("jabber col", 1'b1, col)
        txen <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK("jabber held", 1'b1, col)
        repeat (800) @(posedge clk);
        `CHK("jabber off", 1'b0, col)
    endtask
    task automatic t_loop;
        int n = 0;
        for (int k = 0; k < 200; k++) @(posedge clk) n += stb;
        `CHK("nibble strobes", 10, n)
        lpa <= 4'h8;
        t_mode(eph_pkg::EM_100F);
        txd <= 4'hA;
        txen <= 1'b1;
        for (int k = 0; k < 300 && !(rdv === 1'b1 && rxd === 4'hA); k++)
            @(posedge clk);
        `CHK("rx nibble", 4'hA, rxd)
        `CHK("carrier", 1'b1, crs)
        `CHK("rx error", 1'b0, rer)
        txen <= 1'b0;
        for (int k = 0; k < 300 && crs !== 1'b0; k++) @(posedge clk);
        `CHK("carrier end", 1'b0, crs)
        `CHK("rx end", 1'b0, rdv)
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK("ref sel", 2'h1, refs)
        t_mdio();
        t_an();
        t_tx();
        t_loop();
        end_of_test();
    end
    initial begin
        #400_000;
        err_count++;
        end_of_test();
    end
endmodule
